// ### pkg/vcf_pkg.sv
`default_nettype none
package vcf_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int SLOTS      = 4;
   localparam int SLOT_W     = 2;
   localparam int FIFO_DEPTH = 4;

   // ----------------------------------------------------------------
   // Command field codes
   // ----------------------------------------------------------------
   localparam logic [9:0] CODE_GET_VOICE   = 10'h025;
   localparam logic [9:0] CODE_SET_VOICE   = 10'h026;
   localparam logic [9:0] CODE_GET_DISCARD = 10'h027;

   // ----------------------------------------------------------------
   // Values after reset and encodings
   // ----------------------------------------------------------------
   localparam logic [9:0]  VOICE_RESET  = 10'h060;
   localparam logic [1:0]  CODING_RSVD  = 2'h3;
   localparam logic [11:0] HANDLE_MAX   = 12'hEFF;
   localparam logic [1:0]  PB_START     = 2'h2;
   localparam logic [10:0] DISCARD_OFF  = 11'h000;
   localparam logic [15:0] FAIL_RESET   = 16'h0000;

   // ----------------------------------------------------------------
   // Status codes
   // ----------------------------------------------------------------
   localparam logic [7:0] ST_OK          = 8'h00;
   localparam logic [7:0] ST_UNKNOWN_CMD = 8'h01;
   localparam logic [7:0] ST_NO_LINK     = 8'h02;
   localparam logic [7:0] ST_BAD_PARAM   = 8'h12;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 50;
   localparam int TICK_PERIOD_NS = 625000;
   localparam int TICK_CYC       = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [0:0] {CS_IDLE = 1'b0, CS_EXEC = 1'b1} vcf_state_e;

   // Field order gives bits 9:8, 7:6, 5, 4:2, 1:0
   typedef struct packed {
      logic [1:0] in_coding;
      logic [1:0] data_fmt;
      logic       sample16;
      logic [2:0] pcm_pos;
      logic [1:0] air_coding;
   } vcf_voice_s;

   typedef struct packed {
      logic [9:0]  code;
      logic [15:0] param;
   } vcf_cmd_s;

   typedef struct packed {
      logic [9:0]  code;
      logic [7:0]  status;
      logic [15:0] handle;
      logic [15:0] value;
   } vcf_rsp_s;

   typedef struct packed {
      logic        open;
      logic        acl;
      logic [11:0] handle;
      logic [10:0] timeout;
   } vcf_link_s;

   typedef struct packed {
      logic [SLOT_W-1:0] slot;
      logic [1:0]        pb;
      logic              last;
      logic [7:0]        data;
   } vcf_chunk_s;

endpackage
`default_nettype wire

// ### hw/vcf_cmd_top.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Set-voice code 0x0026 carries one word
// - Get-voice code 0x0025 returns status, word
// - Only low ten voice bits matter
// - One voice setting for all connections
// - Bits 9:8 select input coding
// - Bits 7:6 select input data format
// - Bit 5 selects 8 or 16-bit samples
// - Bits 4:2 give linear MSB offset
// - Bits 1:0 select air coding
// - Voice word resets to 0001100000
// - Status zero success, nonzero error code
// - Completion raises unmasked Command Complete event
// - Get-discard code 0x0027 returns status, handle, timeout
// - Discard timer only on ACL links
// - Timer starts at first packet transmission
// - Expiry discards rest of current packet
// - Each expiry adds one failed contact
// - Buffered next packet may go immediately
// - Else drop data until start flag
// - Start chunk begins new transmission attempt
// - Handle low 12 bits, above 0x0EFF reserved
// - Timeout zero off, else N ticks 0.625ms
// - Reply handle equals requested handle

// ----------------------------------------------------------------
// Chunk FIFO
// ----------------------------------------------------------------
module vcf_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      cnt_reg;
   logic [AW:0]      cnt_next;
   logic             in_ready_reg;
   logic             push;
   logic             pop;

   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction

   assign push      = in_valid && in_ready_reg;
   assign pop       = out_valid && out_ready;
   assign in_ready  = in_ready_reg;
   assign out_valid = (cnt_reg != '0);
   assign out_data  = mem_reg[rd_ptr_reg];

   always_comb begin
      cnt_next = cnt_reg;
      if (push && !pop) begin
         cnt_next = cnt_reg + (AW+1)'(1);
      end else if (pop && !push) begin
         cnt_next = cnt_reg - (AW+1)'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg      <= '0;
         wr_ptr_reg   <= '0;
         rd_ptr_reg   <= '0;
         in_ready_reg <= 1'b1;
      end else begin
         cnt_reg      <= cnt_next;
         in_ready_reg <= (cnt_next != (AW+1)'(DEPTH));
         if (push) begin
            wr_ptr_reg <= ptr_inc(wr_ptr_reg);
         end
         if (pop) begin
            rd_ptr_reg <= ptr_inc(rd_ptr_reg);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end
endmodule // vcf_fifo

// ----------------------------------------------------------------
// Command interpreter and auto-discard engine
// ----------------------------------------------------------------
module vcf_cmd_top #(
   parameter int TICK_CYCLES = vcf_pkg::TICK_CYC
) (
   // Clock and reset
   input  wire logic                 mclk,
   input  wire logic                 rst_n,
   // Command request
   input  wire logic                 cmd_valid,
   output logic                      cmd_ready,
   input  wire vcf_pkg::vcf_cmd_s    cmd,
   // Command Complete event
   input  wire logic                 evt_enable,
   output logic                      evt_valid,
   output vcf_pkg::vcf_rsp_s         evt,
   // Voice setting
   output vcf_pkg::vcf_voice_s       voice_cfg,
   // Link table
   input  wire logic                 link_we,
   input  wire logic [vcf_pkg::SLOT_W-1:0] link_slot,
   input  wire vcf_pkg::vcf_link_s   link_cfg,
   output logic [vcf_pkg::SLOTS-1:0][15:0] fail_cnt,
   output logic [vcf_pkg::SLOTS-1:0] link_discarding,
   // Host data
   input  wire logic                 dat_valid,
   output logic                      dat_ready,
   input  wire vcf_pkg::vcf_chunk_s  dat,
   // Baseband transmit
   output logic                      tx_valid,
   input  wire logic                 tx_ready,
   output vcf_pkg::vcf_chunk_s       tx_chunk
);
   localparam int N  = vcf_pkg::SLOTS;
   localparam int TW = $clog2(TICK_CYCLES + 1);

   vcf_pkg::vcf_state_e  state_reg;
   vcf_pkg::vcf_cmd_s    cmd_reg;
   logic                 cmd_ready_reg;
   vcf_pkg::vcf_rsp_s    rsp_next;
   vcf_pkg::vcf_rsp_s    evt_reg;
   logic                 evt_valid_reg;
   vcf_pkg::vcf_voice_s  voice_reg;
   vcf_pkg::vcf_voice_s  voice_in;
   logic                 voice_we;
   logic                 voice_written_reg;
   logic                 exec;
   logic [vcf_pkg::SLOT_W:0] hit;
   vcf_pkg::vcf_link_s   link_reg [N];
   logic [N-1:0][15:0]   fail_reg;
   logic [N-1:0]         discard_reg;
   logic [N-1:0]         run_reg;
   logic [10:0]          tcnt_reg [N];
   logic [N-1:0]         expire;
   logic [N-1:0]         start_tx;
   logic [N-1:0]         end_tx;
   logic [TW-1:0]        tick_cnt_reg;
   logic                 tick_reg;
   logic                 fifo_out_valid;
   logic                 fifo_out_ready;
   vcf_pkg::vcf_chunk_s  head;
   logic                 pop;
   logic                 drop;
   logic                 push_tx;
   logic                 tx_fire;
   logic                 tx_valid_reg;
   vcf_pkg::vcf_chunk_s  tx_reg;

   function automatic logic voice_reserved(input vcf_pkg::vcf_voice_s v);
      return (v.in_coding == vcf_pkg::CODING_RSVD) || (v.data_fmt == vcf_pkg::CODING_RSVD)
          || (v.air_coding == vcf_pkg::CODING_RSVD);
   endfunction

   // Lowest open slot whose handle matches; MSB is the hit flag
   function automatic logic [vcf_pkg::SLOT_W:0] find_link(input vcf_pkg::vcf_link_s tbl [N],
                                                          input logic [11:0] h);
      logic [vcf_pkg::SLOT_W:0] r;
      r = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (tbl[i].open && (tbl[i].handle == h)) begin
            r = {1'b1, vcf_pkg::SLOT_W'(i)};
         end
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Command sequencing
   // ----------------------------------------------------------------
   assign exec      = (state_reg == vcf_pkg::CS_EXEC);
   assign cmd_ready = cmd_ready_reg;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg     <= vcf_pkg::CS_IDLE;
         cmd_ready_reg <= 1'b1;
         cmd_reg       <= '0;
      end else begin
         case (state_reg)
            vcf_pkg::CS_IDLE: begin
               if (cmd_valid && cmd_ready_reg) begin
                  state_reg     <= vcf_pkg::CS_EXEC;
                  cmd_ready_reg <= 1'b0;
                  cmd_reg       <= cmd;
               end
            end
            default: begin
               state_reg     <= vcf_pkg::CS_IDLE;
               cmd_ready_reg <= 1'b1;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Command execution
   // ----------------------------------------------------------------
   assign voice_in = vcf_pkg::vcf_voice_s'(cmd_reg.param[9:0]);
   assign hit      = find_link(link_reg, cmd_reg.param[11:0]);

   always_comb begin
      rsp_next        = '0;
      rsp_next.code   = cmd_reg.code;
      rsp_next.status = vcf_pkg::ST_OK;
      voice_we        = 1'b0;
      case (cmd_reg.code)
         vcf_pkg::CODE_GET_VOICE: begin
            rsp_next.value = {6'h00, voice_reg};
         end
         vcf_pkg::CODE_SET_VOICE: begin
            if (voice_reserved(voice_in)) begin
               rsp_next.status = vcf_pkg::ST_BAD_PARAM;
            end else begin
               voice_we = 1'b1;
            end
         end
         vcf_pkg::CODE_GET_DISCARD: begin
            rsp_next.handle = cmd_reg.param;
            if (cmd_reg.param[11:0] > vcf_pkg::HANDLE_MAX) begin
               rsp_next.status = vcf_pkg::ST_BAD_PARAM;
            end else if (!hit[vcf_pkg::SLOT_W]) begin
               rsp_next.status = vcf_pkg::ST_NO_LINK;
            end else begin
               rsp_next.value = {5'h00, link_reg[hit[vcf_pkg::SLOT_W-1:0]].timeout};
            end
         end
         default: begin
            rsp_next.status = vcf_pkg::ST_UNKNOWN_CMD;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         evt_valid_reg <= 1'b0;
         evt_reg       <= '0;
      end else begin
         evt_valid_reg <= exec && evt_enable;
         if (exec) begin
            evt_reg <= rsp_next;
         end
      end
   end

   assign evt_valid = evt_valid_reg;
   assign evt       = evt_reg;

   // ----------------------------------------------------------------
   // Voice setting, shared by every voice connection
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         voice_reg         <= vcf_pkg::vcf_voice_s'(vcf_pkg::VOICE_RESET);
         voice_written_reg <= 1'b0;
      end else if (exec && voice_we) begin
         voice_reg         <= voice_in;
         voice_written_reg <= 1'b1;
      end
   end

   assign voice_cfg = voice_reg;

   // ----------------------------------------------------------------
   // Link table and failed contact counters
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < N; i++) begin
            link_reg[i] <= '0;
         end
      end else if (link_we) begin
         link_reg[link_slot] <= link_cfg;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         fail_reg <= '0;
      end else begin
         for (int i = 0; i < N; i++) begin
            if (link_we && (link_slot == vcf_pkg::SLOT_W'(i))) begin
               fail_reg[i] <= expire[i] ? 16'h0001 : vcf_pkg::FAIL_RESET;
            end else if (expire[i]) begin
               fail_reg[i] <= fail_reg[i] + 16'h0001;
            end
         end
      end
   end

   assign fail_cnt = fail_reg;

   // ----------------------------------------------------------------
   // Slot tick divider
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_reg <= '0;
         tick_reg     <= 1'b0;
      end else if (tick_cnt_reg == TW'(TICK_CYCLES - 1)) begin
         tick_cnt_reg <= '0;
         tick_reg     <= 1'b1;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + TW'(1);
         tick_reg     <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Discard timers
   // ----------------------------------------------------------------
   assign tx_fire = tx_valid_reg && tx_ready;

   always_comb begin
      for (int i = 0; i < N; i++) begin
         start_tx[i] = tx_fire && (tx_reg.slot == vcf_pkg::SLOT_W'(i))
                    && (tx_reg.pb == vcf_pkg::PB_START) && link_reg[i].open
                    && link_reg[i].acl && (link_reg[i].timeout != vcf_pkg::DISCARD_OFF);
         end_tx[i]   = tx_fire && (tx_reg.slot == vcf_pkg::SLOT_W'(i)) && tx_reg.last;
         expire[i]   = run_reg[i] && tick_reg
                    && ((tcnt_reg[i] + 11'h001) == link_reg[i].timeout);
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         run_reg <= '0;
         for (int i = 0; i < N; i++) begin
            tcnt_reg[i] <= '0;
         end
      end else begin
         for (int i = 0; i < N; i++) begin
            if (link_we && (link_slot == vcf_pkg::SLOT_W'(i))) begin
               run_reg[i] <= 1'b0;
            end else if (start_tx[i]) begin
               run_reg[i]  <= !tx_reg.last;
               tcnt_reg[i] <= '0;
            end else if (expire[i] || end_tx[i]) begin
               run_reg[i] <= 1'b0;
            end else if (run_reg[i] && tick_reg) begin
               tcnt_reg[i] <= tcnt_reg[i] + 11'h001;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Data path: FIFO, discard filter, transmit stage
   // ----------------------------------------------------------------
   vcf_fifo #(
      .WIDTH ($bits(vcf_pkg::vcf_chunk_s)),
      .DEPTH (vcf_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk       (mclk),
      .rst_n     (rst_n),
      .in_valid  (dat_valid),
      .in_ready  (dat_ready),
      .in_data   (dat),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (head)
   );

   assign fifo_out_ready = !tx_valid_reg || tx_fire;
   assign pop            = fifo_out_valid && fifo_out_ready;
   assign drop           = pop && (discard_reg[head.slot] || expire[head.slot])
                        && (head.pb != vcf_pkg::PB_START);
   assign push_tx        = pop && !drop;

   // A start chunk ends discarding; it wins over an expiry of its slot in the same cycle
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         discard_reg <= '0;
      end else begin
         for (int i = 0; i < N; i++) begin
            if (pop && (head.slot == vcf_pkg::SLOT_W'(i)) && (head.pb == vcf_pkg::PB_START)) begin
               discard_reg[i] <= 1'b0;
            end else if (expire[i]) begin
               discard_reg[i] <= 1'b1;
            end
         end
      end
   end

   assign link_discarding = discard_reg;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tx_valid_reg <= 1'b0;
         tx_reg       <= '0;
      end else if (push_tx) begin
         tx_valid_reg <= 1'b1;
         tx_reg       <= head;
      end else if (tx_fire) begin
         tx_valid_reg <= 1'b0;
      end else if (tx_valid_reg && expire[tx_reg.slot] && (tx_reg.pb != vcf_pkg::PB_START)) begin
         tx_valid_reg <= 1'b0;
      end
   end

   assign tx_valid = tx_valid_reg;
   assign tx_chunk = tx_reg;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_reset_default;
      @(posedge mclk) disable iff (!rst_n)
      !voice_written_reg |-> (voice_reg == vcf_pkg::vcf_voice_s'(vcf_pkg::VOICE_RESET));
   endproperty
   a_reset_default: assert property (p_reset_default) else $error("voice default lost");

   property p_bad_write;
      @(posedge mclk) disable iff (!rst_n)
      (exec && (cmd_reg.code == vcf_pkg::CODE_SET_VOICE) && voice_reserved(voice_in))
      |=> (evt_reg.status != vcf_pkg::ST_OK) && $stable(voice_reg);
   endproperty
   a_bad_write: assert property (p_bad_write) else $error("reserved voice write accepted");

   property p_good_write;
      @(posedge mclk) disable iff (!rst_n)
      (exec && (cmd_reg.code == vcf_pkg::CODE_SET_VOICE) && !voice_reserved(voice_in))
      |=> (voice_reg == $past(voice_in)) && (evt_reg.status == vcf_pkg::ST_OK);
   endproperty
   a_good_write: assert property (p_good_write) else $error("voice write not stored");

   property p_event;
      @(posedge mclk) disable iff (!rst_n)
      (cmd_valid && cmd_ready) |-> ##2 (evt_valid == $past(evt_enable));
   endproperty
   a_event: assert property (p_event) else $error("completion event wrong");

   property p_handle_echo;
      @(posedge mclk) disable iff (!rst_n)
      (cmd_valid && cmd_ready && (cmd.code == vcf_pkg::CODE_GET_DISCARD))
      |-> ##2 (evt_reg.handle == $past(cmd.param, 2));
   endproperty
   a_handle_echo: assert property (p_handle_echo) else $error("handle not echoed");

   property p_no_discarded_tx;
      @(posedge mclk) disable iff (!rst_n)
      (tx_valid_reg && (tx_reg.pb != vcf_pkg::PB_START)) |-> !discard_reg[tx_reg.slot];
   endproperty
   a_no_discarded_tx: assert property (p_no_discarded_tx) else $error("discarded chunk sent");

   property p_ready_cycle;
      @(posedge mclk) disable iff (!rst_n)
      (cmd_valid && cmd_ready) |=> !cmd_ready ##1 cmd_ready;
   endproperty
   a_ready_cycle: assert property (p_ready_cycle) else $error("command ready timing wrong");

   for (genvar g = 0; g < N; g++) begin : g_slot_chk
      property p_fail_inc;
         @(posedge mclk) disable iff (!rst_n)
         (expire[g] && !link_we) |=> (fail_reg[g] == $past(fail_reg[g]) + 16'h0001);
      endproperty
      a_fail_inc: assert property (p_fail_inc) else $error("failed contact not counted");

      property p_acl_only;
         @(posedge mclk) disable iff (!rst_n)
         run_reg[g] |-> (link_reg[g].acl && (link_reg[g].timeout != vcf_pkg::DISCARD_OFF));
      endproperty
      a_acl_only: assert property (p_acl_only) else $error("timer on non-ACL link");

      property p_timer_start;
         @(posedge mclk) disable iff (!rst_n)
         (start_tx[g] && !tx_reg.last && !link_we) |=> run_reg[g] && (tcnt_reg[g] == 11'h000);
      endproperty
      a_timer_start: assert property (p_timer_start) else $error("timer not started");

      property p_expire_flag;
         @(posedge mclk) disable iff (!rst_n)
         (expire[g] && !(pop && (head.slot == vcf_pkg::SLOT_W'(g)) && (head.pb == vcf_pkg::PB_START)))
         |=> discard_reg[g];
      endproperty
      a_expire_flag: assert property (p_expire_flag) else $error("discard not raised");
   end

   c_voice_write: cover property (@(posedge mclk) disable iff (!rst_n)
      exec && voice_we);
   c_expire: cover property (@(posedge mclk) disable iff (!rst_n)
      |expire);
   c_drop: cover property (@(posedge mclk) disable iff (!rst_n)
      drop);
   c_read_ok: cover property (@(posedge mclk) disable iff (!rst_n)
      exec && (cmd_reg.code == vcf_pkg::CODE_GET_DISCARD) && (rsp_next.status == vcf_pkg::ST_OK));
endmodule // vcf_cmd_top
`default_nettype wire

// ### sim/vcf_tx_sink.sv
`timescale 1ns/1ps
`default_nettype none
// Baseband sink: takes chunks with random stalls, or none while hold is high
module vcf_tx_sink (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       hold,
   input  wire logic       tx_valid,
   output logic            tx_ready,
   output logic      [7:0] n_rx
);
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tx_ready <= 1'b0;
         n_rx     <= 8'h00;
      end else begin
         tx_ready <= !hold && ($urandom % 3 != 0);
         if (tx_valid && tx_ready) n_rx <= n_rx + 8'h01;
      end
   end
endmodule // vcf_tx_sink
`default_nettype wire

// ### sim/vcf_cmd_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module vcf_cmd_top_test;
   logic mclk, rst_n, cmd_valid, evt_enable, link_we, dat_valid, hold;
   logic cmd_ready, evt_valid, dat_ready, tx_valid, tx_ready;
   vcf_pkg::vcf_cmd_s   cmd;
   vcf_pkg::vcf_rsp_s   evt;
   vcf_pkg::vcf_voice_s voice_cfg;
   vcf_pkg::vcf_link_s  link_cfg;
   vcf_pkg::vcf_chunk_s dat, tx_chunk;
   logic [1:0]          link_slot;
   logic [3:0][15:0]    fail_cnt;
   logic [3:0]          link_discarding;
   logic [7:0]          n_rx, n0, m, k;
   logic [15:0]         w;
   logic [9:0]          vexp;
   int                  n_fail, n_compared;
   vcf_cmd_top #(.TICK_CYCLES(4)) u_vcf_cmd_top (.mclk(mclk), .rst_n(rst_n),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .evt_enable(evt_enable),
      .evt_valid(evt_valid), .evt(evt), .voice_cfg(voice_cfg), .link_we(link_we),
      .link_slot(link_slot), .link_cfg(link_cfg), .fail_cnt(fail_cnt),
      .link_discarding(link_discarding), .dat_valid(dat_valid), .dat_ready(dat_ready),
      .dat(dat), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_chunk(tx_chunk));
   vcf_tx_sink u_vcf_tx_sink (.mclk(mclk), .rst_n(rst_n), .hold(hold),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .n_rx(n_rx));
   function automatic logic rsvd(input logic [15:0] v);
      return (&v[9:8]) || (&v[7:6]) || (&v[1:0]);
   endfunction
   task automatic chk(input string n, input logic [49:0] e, input logic [49:0] s);
      n_compared++;
      if (s !== e) begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic run_cmd(input logic [9:0] c, input logic [15:0] p, input logic [7:0] st,
                          input logic en);
      @(posedge mclk);
      cmd_valid  <= 1'b1;
      cmd        <= {c, p};
      evt_enable <= en;
      do @(posedge mclk); while (!cmd_ready);
      cmd_valid <= 1'b0;
      @(posedge mclk);
      #1;
      chk("evt_valid", en, evt_valid);
      chk("evt_status", {c, st}, {evt.code, evt.status});
   endtask
   task automatic push(input logic [1:0] s, input logic [1:0] pb, input logic l);
      @(posedge mclk);
      dat_valid <= 1'b1;
      dat       <= {s, pb, l, k};
      do @(posedge mclk); while (!dat_ready);
      dat_valid <= 1'b0;
      k = k + 8'h01;
   endtask
   task automatic complete_run;
      $display("Compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   initial begin
      #250000;
      n_fail++;
      complete_run();
   end
   initial begin
      {rst_n, cmd_valid, link_we, dat_valid, hold, link_slot, evt_enable} = '0;
      {cmd, link_cfg, dat, k} = '0;
      w = 16'($urandom(52));
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      #1;
      chk("voice_rst", 10'h060, voice_cfg);
      vexp = 10'h060;
      for (int i = 0; i < 24; i++) begin
         w = (i == 0) ? 16'hFC5B : 16'($urandom);
         run_cmd(10'h026, w, rsvd(w) ? 8'h12 : 8'h00, 1'b1);
         if (!rsvd(w)) vexp = w[9:0];
         chk("voice_cfg", vexp, voice_cfg);
      end
      run_cmd(10'h025, 16'hFFFF, 8'h00, 1'b0);
      chk("get_voice", {6'h00, vexp}, evt.value);
      run_cmd(10'h3FF, 16'h0000, 8'h01, 1'b1);
      $display("voice test done");
      @(posedge mclk);
      link_we   <= 1'b1;
      link_slot <= 2'd1;
      link_cfg  <= {1'b1, 1'b1, 12'h123, 11'h003};
      @(posedge mclk);
      link_slot <= 2'd2;
      link_cfg  <= {1'b1, 1'b0, 12'hEFF, 11'h001};
      @(posedge mclk);
      link_we <= 1'b0;
      run_cmd(10'h027, 16'hF123, 8'h00, 1'b1);
      chk("handle_value", {16'hF123, 16'h0003}, {evt.handle, evt.value});
      run_cmd(10'h027, 16'h0F00, 8'h12, 1'b1);
      run_cmd(10'h027, 16'h0EFF, 8'h00, 1'b1);
      run_cmd(10'h027, 16'h0456, 8'h02, 1'b1);
      chk("no_link_value", 16'h0000, evt.value);
      $display("timeout read test done");
      n0 = n_rx;
      push(2'd1, 2'h2, 1'b0);
      push(2'd2, 2'h2, 1'b0);
      for (int i = 0; i < 200 && !link_discarding[1]; i++) @(posedge mclk);
      #1;
      chk("discarding", 4'h2, link_discarding);
      chk("fail_cnt", {16'h0001, 16'h0000}, {fail_cnt[1], fail_cnt[2]});
      push(2'd1, 2'h1, 1'b1);
      repeat (20) @(posedge mclk);
      chk("dropped", n0 + 8'd2, n_rx);
      push(2'd1, 2'h2, 1'b1);
      repeat (20) @(posedge mclk);
      #1;
      chk("restart", {n0 + 8'd3, 4'h0}, {n_rx, link_discarding});
      chk("tx_chunk", {2'd1, 2'h2, 1'b1, k - 8'h01}, tx_chunk);
      $display("discard test done");
      @(posedge mclk);
      hold <= 1'b1;
      repeat (3) @(posedge mclk);
      n0 = n_rx;
      m = 8'h00;
      dat_valid <= 1'b1;
      dat       <= {2'd0, 2'h2, 1'b1, 8'hA5};
      for (int i = 0; i < 12; i++) begin
         @(posedge mclk);
         if (dat_ready) m = m + 8'h01;
      end
      dat_valid <= 1'b0;
      hold      <= 1'b0;
      chk("fill", 8'd5, m);
      repeat (40) @(posedge mclk);
      chk("drained", n0 + m, n_rx);
      $display("buffer test done");
      complete_run();
   end
endmodule // vcf_cmd_top_test
`default_nettype wire
